// ==== rdc_exc_pkg.sv ====
// constants, field positions and carrier types of the excitation setting block
package rdc_exc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int WORD_LSB = 2;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] EXC_SETTING_OFFSET = 8'h4C;
    localparam logic [DATA_W-1:0] EXC_SETTING_RESET = 32'h0A00_0000;
    // writable bits: 28, 27, 25, 24, 21:20, 17:16, 15:0
    localparam logic [DATA_W-1:0] EXC_SETTING_WMASK = 32'h1B33_FFFF;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NFS_BIT = 28;
    localparam int EXT_BIT = 27;
    localparam int SEL_BIT = 25;
    localparam int COMP_BIT = 24;
    localparam int SRC_LSB = 20;
    localparam int SHAPE_LSB = 16;
    localparam int DLY_LSB = 0;
    localparam int DLY_W = 16;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_TIMER = 2'h1;
    localparam logic [1:0] SRC_PIN = 2'h2;
    localparam logic [1:0] SHAPE_PULSE = 2'h1;
    localparam logic [1:0] SHAPE_BAD = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int DELAY_LSB_NS = 50;
    localparam int FILTER_NS = 2000;
    // least time: round up
    localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_W = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } avl_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
    } avl_rsp_t;

    typedef struct packed {
        logic vr_active;
        logic dc_active;
        logic select_conflict;
        logic shape_pulse;
        logic shape_prohibited;
    } exc_status_t;

endpackage

// ==== pulse_noise_filter.sv ====
// noise filter for one extracted pulse signal
module pulse_noise_filter
    import rdc_exc_pkg::*;
#(
    parameter int STABLE_CYCLES = FILTER_CYCLES
)
(
    input logic clk,
    input logic rst_n,
    input logic enable,
    input logic raw,
    output logic filtered
);

    // ------------------------------------------------------------
    // stability counter
    // ------------------------------------------------------------
    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic out_r;
    logic out_nxt;
    wire differs = raw != out_r;
    wire settled = differs && (cnt_r == CNT_LAST);

    // level must differ for the full window before it passes
    assign cnt_nxt = (!enable || !differs || settled) ? '0 : cnt_r + CNT_W'(1);
    assign out_nxt = (!enable || settled) ? raw : out_r;
    assign filtered = out_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_filter_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> out_r == $past(raw))
        else $error("filter bypass did not follow input");
    a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (enable && differs && cnt_r != CNT_LAST) |=> $stable(out_r) || !$past(enable))
        else $error("filter passed a short glitch");

endmodule // pulse_noise_filter

// ==== phase_delay_line.sv ====
// programmable delay of the external excitation phase signal in 50 ns steps
module phase_delay_line
    import rdc_exc_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input logic [DLY_W-1:0] delay_count,
    input logic phase_in,
    output logic phase_out
);

    // ------------------------------------------------------------
    // 50 ns tick from fractional accumulator
    // ------------------------------------------------------------
    // 40 ns clock cannot divide to 50 ns evenly; mean rate is exact, jitter one clock
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(DELAY_LSB_NS);

    logic [ACC_W-1:0] acc_r;
    wire [ACC_W-1:0] acc_sum = acc_r + ACC_STEP;
    wire tick = acc_sum >= ACC_WRAP;
    wire [ACC_W-1:0] acc_nxt = tick ? acc_sum - ACC_WRAP : acc_sum;

    // ------------------------------------------------------------
    // edge tracking and countdown
    // ------------------------------------------------------------
    logic prev_r;
    logic pending_r;
    logic target_r;
    logic out_r;
    logic [DLY_W-1:0] cnt_r;
    wire edge_seen = phase_in != prev_r;
    wire expire = pending_r && (cnt_r == '0);

    assign phase_out = out_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_r <= '0;
            prev_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            prev_r <= phase_in;
        end
    end

    // delay value sampled only at an edge; a later edge restarts the count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_r <= 1'b0;
            target_r <= 1'b0;
            cnt_r <= '0;
            out_r <= 1'b0;
        end
        else if (edge_seen)
        begin
            pending_r <= 1'b1;
            target_r <= phase_in;
            cnt_r <= delay_count;
        end
        else if (expire)
        begin
            pending_r <= 1'b0;
            out_r <= target_r;
        end
        else if (pending_r && tick)
        begin
            cnt_r <= cnt_r - DLY_W'(1);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // four ticks in every five clocks; the gap follows the fourth
    a_tick_rate: assert property (@(posedge clk) disable iff (!rst_n)
        (tick ##1 !tick) |=> tick[*4] ##1 !tick)
        else $error("tick pattern lost its four in five rate");
    a_delay_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (pending_r && cnt_r != '0 && !edge_seen) |=> $stable(out_r))
        else $error("delayed phase moved before count ran out");
    a_delay_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (edge_seen && delay_count == '0) |=> ##1 out_r == $past(phase_in, 2) || $past(edge_seen))
        else $error("zero delay did not pass the edge");

endmodule // phase_delay_line

// ==== resolver_excitation_config.sv ====
// excitation setting register and excitation phase path of the resolver converter
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module resolver_excitation_config
    import rdc_exc_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input avl_req_t avl_req,
    output avl_rsp_t avl_rsp,
    input logic phase_adc,
    input logic phase_pin,
    input logic phase_timer,
    input logic sin_pulse_raw,
    input logic cos_pulse_raw,
    output logic sin_pulse,
    output logic cos_pulse,
    output logic excitation_phase,
    output logic extraction_enable,
    output exc_status_t status
);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait cycle per access keeps read data registered
    logic ack_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] ref_r;

    wire req = avl_req.read || avl_req.write;
    wire hit = avl_req.address[ADDR_W-1:WORD_LSB] == EXC_SETTING_OFFSET[ADDR_W-1:WORD_LSB];
    wire ack_nxt = req && !ack_r;
    wire wr_take = avl_req.write && ack_r && hit;

    assign avl_rsp.waitrequest = !ack_r;
    assign avl_rsp.readdata = rdata_r;

    // ------------------------------------------------------------
    // byte lane merge
    // ------------------------------------------------------------
    logic [DATA_W-1:0] be_mask;
    genvar g;
    generate
        for (g = 0; g < BE_W; g++)
        begin : g_lane
            assign be_mask[g*8 +: 8] = {8{avl_req.byteenable[g]}};
        end
    endgenerate

    wire [DATA_W-1:0] upd_mask = be_mask & EXC_SETTING_WMASK;
    // reserved bits forced to reset value so nothing else can appear
    wire [DATA_W-1:0] ref_nxt = (ref_r & ~upd_mask) | (avl_req.writedata & upd_mask);
    wire [DATA_W-1:0] rd_word = hit ? ref_r : READ_UNMAPPED;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            ack_r <= ack_nxt;
            rdata_r <= ack_nxt ? rd_word : rdata_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_r <= EXC_SETTING_RESET;
        end
        else if (wr_take)
        begin
            ref_r <= ref_nxt;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire nfs_sel = ref_r[NFS_BIT];
    wire ext_en = ref_r[EXT_BIT];
    wire sensor_select = ref_r[SEL_BIT];
    wire sensor_select_companion = ref_r[COMP_BIT];
    wire [1:0] excitation_phase_source = ref_r[SRC_LSB +: 2];
    wire [1:0] phase_shape_select = ref_r[SHAPE_LSB +: 2];
    wire [DLY_W-1:0] phase_delay_count = ref_r[DLY_LSB +: DLY_W];

    wire vr_sel = sensor_select && !sensor_select_companion;
    wire dc_sel = !sensor_select && sensor_select_companion;
    // inconsistent pair selects neither sensor; flagged for software
    wire conflict = !vr_sel && !dc_sel;
    // shape 00 needed for sine excitation is also the reset code
    wire shape_pulse = phase_shape_select == SHAPE_PULSE;
    wire shape_bad = phase_shape_select == SHAPE_BAD;

    // ------------------------------------------------------------
    // excitation phase path
    // ------------------------------------------------------------
    logic pin_delayed;

    phase_delay_line u_delay (
        .clk(clk),
        .rst_n(rst_n),
        .delay_count(phase_delay_count),
        .phase_in(phase_pin),
        .phase_out(pin_delayed)
    );

    wire phase_sel = (excitation_phase_source == SRC_PIN) ? pin_delayed :
                     (excitation_phase_source == SRC_TIMER) ? phase_timer :
                     phase_adc;

    // ------------------------------------------------------------
    // extracted pulse filtering
    // ------------------------------------------------------------
    wire [1:0] pulse_raw = {cos_pulse_raw, sin_pulse_raw};
    logic [1:0] pulse_filt;

    generate
        for (g = 0; g < 2; g++)
        begin : g_filt
            pulse_noise_filter u_filt (
                .clk(clk),
                .rst_n(rst_n),
                .enable(nfs_sel),
                .raw(pulse_raw[g]),
                .filtered(pulse_filt[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic sin_r;
    logic cos_r;
    logic phase_r;
    logic ext_r;
    exc_status_t status_r;
    exc_status_t status_nxt;

    assign status_nxt.vr_active = vr_sel;
    assign status_nxt.dc_active = dc_sel;
    assign status_nxt.select_conflict = conflict;
    assign status_nxt.shape_pulse = shape_pulse;
    assign status_nxt.shape_prohibited = shape_bad;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sin_r <= 1'b0;
            cos_r <= 1'b0;
            phase_r <= 1'b0;
            ext_r <= 1'b0;
            status_r <= '0;
        end
        else
        begin
            // disabled extraction holds pulses low
            sin_r <= ext_en && pulse_filt[0];
            cos_r <= ext_en && pulse_filt[1];
            phase_r <= phase_sel;
            ext_r <= ext_en;
            status_r <= status_nxt;
        end
    end

    assign sin_pulse = sin_r;
    assign cos_pulse = cos_r;
    assign excitation_phase = phase_r;
    assign extraction_enable = ext_r;
    assign status = status_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_access_waits;
        req && !ack_r;
    endsequence

    sequence s_full_write;
        avl_req.write && ack_r && hit && avl_req.byteenable == '1;
    endsequence

    a_bus_answer: assert property (s_access_waits |=> !avl_rsp.waitrequest)
        else $error("access not answered after one wait cycle");
    a_write_lands: assert property (s_full_write |=> ref_r ==
        ((EXC_SETTING_RESET & ~EXC_SETTING_WMASK) | ($past(avl_req.writedata) & EXC_SETTING_WMASK)))
        else $error("full word write did not land");
    a_reserved_fixed: assert property ((ref_r & ~EXC_SETTING_WMASK) ==
        (EXC_SETTING_RESET & ~EXC_SETTING_WMASK))
        else $error("reserved bit left its reset value");
    a_lane_guard: assert property ((wr_take && !avl_req.byteenable[3]) |=>
        ref_r[31:24] == $past(ref_r[31:24]))
        else $error("disabled byte lane was written");
    a_read_back: assert property ((avl_req.read && ack_r && hit) |-> avl_rsp.readdata == ref_r)
        else $error("read data differs from register");
    a_extract_gate: assert property (!ext_en |=> !sin_pulse && !cos_pulse)
        else $error("pulse passed while extraction off");
    a_sensor_decode: assert property (status.vr_active |->
        $past(sensor_select) && !$past(sensor_select_companion) && !status.dc_active)
        else $error("variable reluctance flag without matching bits");
    a_source_timer: assert property ((excitation_phase_source == SRC_TIMER) |=>
        excitation_phase == $past(phase_timer))
        else $error("timer source not routed");
    a_source_adc: assert property ((excitation_phase_source[1] == excitation_phase_source[0]) |=>
        excitation_phase == $past(phase_adc))
        else $error("converter source not routed");
    a_shape_flag: assert property (status.shape_pulse |-> $past(phase_shape_select) == SHAPE_PULSE)
        else $error("pulse shape flag wrong");

    // ------------------------------------------------------------
    // further checks on bus, decode and output paths
    // ------------------------------------------------------------
    sequence s_lane_write_low;
        wr_take && avl_req.byteenable[1:0] == 2'h3;
    endsequence

    a_idle_waits: assert property (!req |=> avl_rsp.waitrequest)
        else $error("waitrequest low without a request");

    a_one_wait: assert property (ack_r |=> !ack_r)
        else $error("waitrequest low for more than one cycle");

    a_rdata_hold: assert property (!ack_nxt |=> $stable(avl_rsp.readdata))
        else $error("read data moved between accesses");

    a_write_gate: assert property (!wr_take |=> $stable(ref_r))
        else $error("register changed without a taken write");

    a_unmapped_read: assert property ((avl_req.read && ack_r && !hit) |->
        avl_rsp.readdata == READ_UNMAPPED)
        else $error("unmapped read returned data");

    a_half_write: assert property (s_lane_write_low |=>
        ref_r[15:0] == $past(avl_req.writedata[15:0]))
        else $error("halfword write did not land");

    a_lane0_guard: assert property ((wr_take && !avl_req.byteenable[0]) |=>
        ref_r[7:0] == $past(ref_r[7:0]))
        else $error("byte lane 0 written while disabled");

    a_lane1_guard: assert property ((wr_take && !avl_req.byteenable[1]) |=>
        ref_r[15:8] == $past(ref_r[15:8]))
        else $error("byte lane 1 written while disabled");

    a_lane2_guard: assert property ((wr_take && !avl_req.byteenable[2]) |=>
        ref_r[23:16] == $past(ref_r[23:16]))
        else $error("byte lane 2 written while disabled");

    a_ext_follow: assert property ($changed(ext_en) |=>
        extraction_enable == $past(ext_en))
        else $error("extraction enable output did not follow");

    a_sin_path: assert property (ext_en |=>
        sin_pulse == $past(pulse_filt[0]))
        else $error("sine pulse path broken");

    a_cos_path: assert property (ext_en |=>
        cos_pulse == $past(pulse_filt[1]))
        else $error("cosine pulse path broken");

    a_pin_route: assert property ((excitation_phase_source == SRC_PIN) |=>
        excitation_phase == $past(pin_delayed))
        else $error("external pin source not routed");

    a_dc_decode: assert property (status.dc_active |->
        !$past(sensor_select) && $past(sensor_select_companion) && !status.vr_active)
        else $error("dc resolver flag without matching bits");

    a_conflict_flag: assert property (status.select_conflict |->
        $past(sensor_select) == $past(sensor_select_companion))
        else $error("conflict flag with consistent sensor bits");

    a_shape_square: assert property ((phase_shape_select[1] == phase_shape_select[0]) |=>
        !status.shape_pulse && !status.shape_prohibited)
        else $error("square wave shape flagged as other");

    a_shape_bad: assert property (status.shape_prohibited |->
        $past(phase_shape_select) == SHAPE_BAD)
        else $error("prohibited shape flag wrong");

endmodule // resolver_excitation_config

// ==== resolver_front_model.sv ====
// behavioural model of the resolver front end feeding phase and pulse signals
module resolver_front_model
(
    input logic clk,
    input logic rst_n,
    input logic pin_cmd,
    input logic pulse_cmd,
    output logic phase_adc,
    output logic phase_pin,
    output logic phase_timer,
    output logic sin_pulse_raw,
    output logic cos_pulse_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // free running sources
    // ------------------------------------------------------------
    // two different periods so a wrong source choice shows
    logic [4:0] cnt_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= 5'h00;
        else
            cnt_r <= cnt_r + 5'h01;
    end

    assign phase_adc = cnt_r[3];
    assign phase_timer = cnt_r[2];

    // ------------------------------------------------------------
    // commanded levels, launched on the clock
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_pin <= 1'b0;
            sin_pulse_raw <= 1'b0;
            cos_pulse_raw <= 1'b0;
        end
        else
        begin
            phase_pin <= pin_cmd;
            sin_pulse_raw <= pulse_cmd;
            cos_pulse_raw <= pulse_cmd;
        end
    end
endmodule // resolver_front_model

// ==== resolver_excitation_config_test.sv ====
// self-checking bench of the excitation setting block
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module resolver_excitation_config_test
    import rdc_exc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam logic [7:0] OFS = 8'h4C;
    logic clk;
    logic rst_n;
    avl_req_t avl_req;
    avl_rsp_t avl_rsp;
    logic pin_cmd;
    logic pulse_cmd;
    logic phase_adc;
    logic phase_pin;
    logic phase_timer;
    logic sin_pulse_raw;
    logic cos_pulse_raw;
    logic sin_pulse;
    logic cos_pulse;
    logic excitation_phase;
    logic extraction_enable;
    exc_status_t status;
    logic [31:0] q;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    resolver_excitation_config resolver_excitation_config_inst (.clk(clk), .rst_n(rst_n), .avl_req(avl_req),
        .avl_rsp(avl_rsp), .phase_adc(phase_adc), .phase_pin(phase_pin), .phase_timer(phase_timer),
        .sin_pulse_raw(sin_pulse_raw), .cos_pulse_raw(cos_pulse_raw), .sin_pulse(sin_pulse),
        .cos_pulse(cos_pulse), .excitation_phase(excitation_phase), .extraction_enable(extraction_enable),
        .status(status));

    resolver_front_model resolver_front_model_inst (.clk(clk), .rst_n(rst_n), .pin_cmd(pin_cmd),
        .pulse_cmd(pulse_cmd), .phase_adc(phase_adc), .phase_pin(phase_pin), .phase_timer(phase_timer),
        .sin_pulse_raw(sin_pulse_raw), .cos_pulse_raw(cos_pulse_raw));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // bus and closing tasks
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
        output logic [31:0] rdat);
        @(posedge clk);
        avl_req <= '{read: !wr, write: wr, address: a, byteenable: be, writedata: d};
        // held until the rising edge that sees waitrequest low; data taken there
        do
            @(posedge clk);
        while (avl_rsp.waitrequest !== 1'b0);
        rdat = avl_rsp.readdata;
        avl_req.read <= 1'b0;
        avl_req.write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, be, d, x);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 4'hF, 32'h0000_0000, q);
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // budget of under a thousand cycles with wide margin
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(OFS);
        `CHK(q, 32'h0A00_0000)
        `CHK(extraction_enable, 1'b1)
        `CHK(status.vr_active, 1'b1)
        `CHK(status.dc_active, 1'b0)
        $display("done: reset values");
    endtask

    task automatic t_lanes();
        logic [31:0] e;
        // reserved bits written with their reset value
        wr(OFS, 4'hF, 32'h1B33_FFFF);
        rd(OFS);
        `CHK(q, 32'h1B33_FFFF)
        wr(OFS, 4'hF, 32'h0000_0000);
        e = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS, 4'h1 << i, 32'h1B33_FFFF);
            e[i*8 +: 8] = 8'hFF;
            rd(OFS);
            `CHK(q, e & 32'h1B33_FFFF)
        end
        wr(OFS, 4'hC, 32'h0000_0000);
        rd(OFS);
        `CHK(q, 32'h0000_FFFF)
        rd(8'h48);
        `CHK(q, 32'h0000_0000)
        wr(8'h50, 4'hF, 32'h0000_0000);
        rd(OFS);
        `CHK(q, 32'h0000_FFFF)
        $display("done: lanes and reserved bits");
    endtask

    task automatic t_decode();
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS, 4'hF, 32'h0800_0000 | (32'(i) << 24) | (32'(i) << 16));
            repeat (2) @(negedge clk);
            `CHK(status.vr_active, (i == 2))
            `CHK(status.dc_active, (i == 1))
            `CHK(status.select_conflict, (i == 0 || i == 3))
            `CHK(status.shape_pulse, (i == 1))
            `CHK(status.shape_prohibited, (i == 2))
        end
        $display("done: sensor and shape decode");
    endtask

    task automatic t_source();
        logic prev;
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
                continue;
            // shape kept at 00 for a sinusoidal excitation
            wr(OFS, 4'hF, 32'h0A00_0000 | (32'(i) << 20));
            repeat (2) @(negedge clk);
            prev = (i == 1) ? phase_timer : phase_adc;
            repeat (40)
            begin
                @(negedge clk);
                `CHK(excitation_phase, prev)
                prev = (i == 1) ? phase_timer : phase_adc;
            end
        end
        $display("done: phase source");
    endtask

    task automatic t_delay(input logic [15:0] d);
        int n;
        int lo;
        logic tgt;
        // new count written while the pin is quiet, used by the next edge
        wr(OFS, 4'hF, 32'h0A20_0000 | 32'(d));
        repeat (8 + 2 * int'(d)) @(negedge clk);
        tgt = !phase_pin;
        @(posedge clk);
        pin_cmd <= tgt;
        @(posedge clk);
        n = 0;
        lo = (int'(d) * 5) / 4 + 2;
        @(negedge clk);
        while (excitation_phase !== tgt && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK((n >= lo && n <= lo + 3), 1'b1)
        $display("done: pin delay %0d took %0d cycles", d, n);
    endtask

    task automatic pulse(input int len, input int span, output int cs, output int cc, output int first);
        cs = 0;
        cc = 0;
        first = -1;
        for (int i = 0; i < span; i++)
        begin
            @(posedge clk);
            pulse_cmd <= (i < len);
            @(negedge clk);
            cs += int'(sin_pulse === 1'b1);
            cc += int'(cos_pulse === 1'b1);
            if (first < 0 && sin_pulse === 1'b1)
                first = i;
        end
    endtask

    task automatic t_pulse();
        int cs;
        int cc;
        int f;
        wr(OFS, 4'hF, 32'h0200_0000);
        pulse(10, 20, cs, cc, f);
        `CHK(extraction_enable, 1'b0)
        `CHK(cs + cc, 0)
        wr(OFS, 4'hF, 32'h0A00_0000);
        pulse(3, 20, cs, cc, f);
        `CHK(cs, 3)
        `CHK(cc, 3)
        wr(OFS, 4'hF, 32'h1A00_0000);
        pulse(10, 80, cs, cc, f);
        `CHK(cs + cc, 0)
        pulse(100, 170, cs, cc, f);
        `CHK(cs, 100)
        `CHK(cc, 100)
        `CHK((f >= 51 && f <= 55), 1'b1)
        $display("done: pulse filter and gating");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        avl_req = '0;
        pin_cmd = 1'b0;
        pulse_cmd = 1'b0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lanes();
        t_decode();
        t_source();
        t_delay(16'h0000);
        t_delay(16'h0001);
        t_delay(16'h0004);
        t_delay(16'h0028);
        t_pulse();
        test_done();
    end
endmodule // resolver_excitation_config_test
